// ==== rtl/atc_pkg.sv ====
/*
  constants and carrier types for the cell transmission convergence block.
  assumes a byte-wide line path on one 125 MHz clock.
*/
package atc_pkg;
  // cell geometry
  localparam logic [5:0] POS_HEC = 6'h04; // header check octet index
  localparam logic [5:0] POS_PAY = 6'h05; // first payload octet index
  localparam logic [5:0] POS_LAST = 6'h34; // octet 52, last of 53
  localparam logic [5:0] EMIT_HDR = 6'h04; // header octets passed upward
  localparam logic [5:0] EMIT_LAST = 6'h33; // 52 octets passed upward
  // header check code
  localparam logic [7:0] GEN_POLY = 8'h07; // x^8+x^2+x+1 low terms
  localparam logic [7:0] COSET = 8'h55;
  localparam logic [31:0] IDLE_HDR = 32'h00000001;
  localparam logic [7:0] IDLE_HEC = 8'h52;
  localparam logic [7:0] IDLE_PAY = 8'h6A;
  localparam int SCR_LEN = 43; // x^43+1 delay
  // thresholds
  localparam logic [3:0] ALPHA_RST = 4'h7;
  localparam logic [3:0] DELTA_RST = 4'h6;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DROP = 8'h08;
  localparam int CTRL_ALPHA_LSB = 0;
  localparam int CTRL_DELTA_LSB = 8;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LCD_BIT = 2;
  localparam int STAT_CORR_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // delineation states
  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_PRES = 2'b01,
    ST_SYNC = 2'b10
  } atc_state_t;
  // one octet of a cell stream
  typedef struct packed {
    logic valid;
    logic sop;
    logic [7:0] data;
  } atc_byte_t;
endpackage

// ==== rtl/atc_tc.sv ====
/*
  cell transmission convergence: transmit header check, idle insertion and
  scrambling; receive delineation, descrambling, correction, idle removal.
  assumes line octets arrive and leave one per clk; receive octets may sit at any bit offset.
*/
// Summary of operation
// [RULE_01] check octet is header times x^8 mod generator
// [RULE_02] first header bit is highest order term
// [RULE_03] remainder starts at zero every header
// [RULE_04] transmit check is xored with 01010101
// [RULE_05] receiver removes same pattern before syndrome
// [RULE_06] delineate on 32 header, 8 check bits
// [RULE_07] idle header is 0,0,0,1 and 01010010
// [RULE_08] idle payload is 48 octets of 01101010
// [RULE_09] idle cells inserted, never passed upward
// [RULE_10] hunt tests every bit, match enters presync
// [RULE_11] delta good headers to sync, bad to hunt
// [RULE_12] alpha consecutive bad headers lose delineation
// [RULE_13] correct means zero syndrome, not corrected
// [RULE_14] alpha and delta settable, defaults 7, 6
// [RULE_15] self-synchronising x^43+1 payload scrambling
// [RULE_16] scrambler paused and held during header
// [RULE_17] descrambler off in hunt, payload only else
// [RULE_18] cell is 53 octets, 5 header octets
// [RULE_19] correct single errors, then detect until clean
// [RULE_20] loss raises status until sync regained
// [RULE_21] idle compare after coset removal
`timescale 1ns/1ps
`default_nettype none
module atc_tc (
  input wire logic clk,
  input wire logic sys_rst,
  input wire atc_pkg::atc_byte_t tx_cell,
  output logic tx_ready,
  output atc_pkg::atc_byte_t tx_line,
  input wire logic [7:0] rx_line,
  output atc_pkg::atc_byte_t rx_cell,
  output logic lcd,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // crc over one octet, msb first is highest order term
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[7] ^ d[i]; // [RULE_02]
      r = {r[6:0], 1'b0} ^ (fb ? atc_pkg::GEN_POLY : 8'h00); // [RULE_01]
    end
    return r;
  endfunction

  // check remainder of a 32 bit header, register starting at zero
  function automatic logic [7:0] crc_hdr(input logic [31:0] h);
    logic [7:0] r;
    r = 8'h00; // [RULE_03]
    for (int i = 3; i >= 0; i--) begin
      r = crc_byte(r, h[8*i +: 8]);
    end
    return r;
  endfunction

  // syndrome of a 40 bit header with the coset already taken off
  function automatic logic [7:0] syn_raw(input logic [39:0] c);
    return crc_hdr(c[39:8]) ^ c[7:0];
  endfunction

  // error mask for a single bit error with this syndrome, else zero
  function automatic logic [39:0] err_mask(input logic [7:0] s);
    logic [39:0] m;
    m = 40'h0;
    for (int j = 0; j < 40; j++) begin
      if (syn_raw(40'h1 << j) == s) begin
        m = 40'h1 << j;
      end
    end
    return m;
  endfunction

  // x^43+1 over one octet; returns {new state, output octet}
  function automatic logic [50:0] scr_step(input logic [42:0] s,
                                           input logic [7:0] d,
                                           input logic descr);
    logic [42:0] st;
    logic [7:0] o;
    st = s;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ st[42]; // [RULE_15]
      st = {st[41:0], descr ? d[i] : o[i]};
    end
    return {st, o};
  endfunction

  // ---------------- register file state
  logic [3:0] alpha; // loss threshold
  logic [3:0] delta; // sync threshold
  logic [15:0] drop_cnt; // errored headers discarded in sync

  // ---------------- transmit path
  logic [5:0] tx_pos; // octet index within the outgoing cell
  logic tx_user; // current cell comes from the user side
  logic [7:0] tx_crc; // running header remainder
  logic [31:0] tx_hdr; // header octets sent so far
  logic [42:0] tx_scr; // scrambler history
  logic tx_acc; // an input octet is taken
  logic user_now; // this octet belongs to a user cell
  logic [7:0] tx_raw; // octet before scrambling
  logic [50:0] tx_step; // scrambler result

  // start a user cell only on sop, otherwise an idle cell goes out
  always_comb begin
    if (tx_pos == 6'h00) begin
      tx_ready = tx_cell.valid && tx_cell.sop; // [RULE_09]
      user_now = tx_cell.valid && tx_cell.sop;
    end else begin
      tx_ready = tx_user && (tx_pos != atc_pkg::POS_HEC);
      user_now = tx_user;
    end
  end
  assign tx_acc = tx_ready && tx_cell.valid;

  // octet choice: user data, idle pattern or header check
  always_comb begin
    if (tx_pos < atc_pkg::POS_HEC) begin
      if (user_now) begin
        tx_raw = tx_acc ? tx_cell.data : 8'h00;
      end else begin
        tx_raw = atc_pkg::IDLE_HDR[8*(3-tx_pos[1:0]) +: 8]; // [RULE_07]
      end
    end else if (tx_pos == atc_pkg::POS_HEC) begin
      tx_raw = tx_crc ^ atc_pkg::COSET; // [RULE_04]
    end else if (user_now) begin
      tx_raw = tx_acc ? tx_cell.data : 8'h00;
    end else begin
      tx_raw = atc_pkg::IDLE_PAY; // [RULE_08]
    end
  end
  assign tx_step = scr_step(tx_scr, tx_raw, 1'b0);

  // octet counter over 53 octets
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_pos <= 6'h00;
      tx_user <= 1'b0;
    end else begin
      tx_pos <= (tx_pos == atc_pkg::POS_LAST) ? 6'h00 : tx_pos + 6'h01;
      tx_user <= user_now; // [RULE_18]
    end
  end

  // header remainder and header capture
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_crc <= 8'h00;
      tx_hdr <= 32'h0;
    end else if (tx_pos == 6'h00) begin
      tx_crc <= crc_byte(8'h00, tx_raw); // [RULE_03]
      tx_hdr <= {24'h0, tx_raw};
    end else if (tx_pos < atc_pkg::POS_HEC) begin
      tx_crc <= crc_byte(tx_crc, tx_raw); // [RULE_01]
      tx_hdr <= {tx_hdr[23:0], tx_raw};
    end
  end

  // scrambler only moves over the information field
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_scr <= 43'h0;
    end else if (tx_pos >= atc_pkg::POS_PAY) begin
      tx_scr <= tx_step[50:8]; // [RULE_16]
    end
  end

  // line output register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_line <= '0;
    end else begin
      tx_line.valid <= 1'b1;
      tx_line.sop <= (tx_pos == 6'h00);
      if (tx_pos >= atc_pkg::POS_PAY) begin
        tx_line.data <= tx_step[7:0]; // [RULE_15]
      end else begin
        tx_line.data <= tx_raw;
      end
    end
  end

  // ---------------- receive path
  atc_pkg::atc_state_t state, next_state;
  logic [47:0] rx_sr; // last six line octets, newest low
  logic [7:0] hit; // zero syndrome at each bit offset
  logic hit_any; // some offset matches
  logic [2:0] hit_k; // lowest matching offset
  logic [2:0] rx_off; // locked bit offset
  logic [5:0] rx_pos; // aligned octet index
  logic [3:0] cnt; // consecutive good or bad headers
  logic corr_mode; // single bit correction allowed
  logic [39:0] cand; // assumed header at locked offset
  logic [7:0] rx_syn; // its syndrome
  logic [39:0] emask; // correction mask
  logic chk, ok, fixable, good, idle, fwd;
  logic [31:0] hdr_fix; // header after correction
  logic dscr_en; // descrambler running
  logic [42:0] rx_dsc; // descrambler history
  logic [50:0] rx_step; // descrambler result
  logic [7:0] pdly [0:3]; // payload delay behind header
  logic [31:0] rx_hdr; // header handed upward
  logic emit_act; // a cell is going up
  logic [5:0] ecnt; // octet index of that cell

  // every bit offset tested in parallel over the window
  for (genvar k = 0; k < 8; k++) begin : g_hunt
    assign hit[k] = (syn_raw(rx_sr[k+39:k] ^ {32'h0, atc_pkg::COSET})
                     == 8'h00); // [RULE_10]
  end

  // lowest matching offset wins
  always_comb begin
    hit_any = 1'b0;
    hit_k = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (hit[k]) begin
        hit_any = 1'b1;
        hit_k = 3'(k);
      end
    end
  end

  // header check at the locked offset
  assign cand = rx_sr[rx_off +: 40]; // [RULE_06]
  assign rx_syn = syn_raw(cand ^ {32'h0, atc_pkg::COSET}); // [RULE_05]
  assign chk = (state != atc_pkg::ST_HUNT) && (rx_pos == atc_pkg::POS_HEC);
  assign ok = (rx_syn == 8'h00); // [RULE_13]
  assign emask = err_mask(rx_syn);
  assign fixable = corr_mode && !ok && (emask != 40'h0); // [RULE_19]
  assign hdr_fix = cand[39:8] ^ emask[39:8];
  assign good = ok || fixable;
  assign idle = good && (hdr_fix == atc_pkg::IDLE_HDR); // [RULE_21]
  assign fwd = chk && (state == atc_pkg::ST_SYNC) && good && !idle; // [RULE_09]

  // delineation state machine
  always_comb begin
    next_state = state;
    unique case (state)
      atc_pkg::ST_HUNT: begin
        if (hit_any) next_state = atc_pkg::ST_PRES; // [RULE_10]
      end
      atc_pkg::ST_PRES: begin
        if (chk && !ok) begin
          next_state = atc_pkg::ST_HUNT; // [RULE_11]
        end else if (chk && (cnt + 4'h1 >= delta)) begin
          next_state = atc_pkg::ST_SYNC; // [RULE_11]
        end
      end
      atc_pkg::ST_SYNC: begin
        if (chk && !ok && (cnt + 4'h1 >= alpha)) begin
          next_state = atc_pkg::ST_HUNT; // [RULE_12]
        end
      end
      default: next_state = atc_pkg::ST_HUNT;
    endcase
  end

  // state, offset lock and header counters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= atc_pkg::ST_HUNT;
      rx_off <= 3'h0;
      cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state == atc_pkg::ST_HUNT) begin
        rx_off <= hit_k;
        cnt <= 4'h0;
      end else if (next_state != state) begin
        cnt <= 4'h0;
      end else if (chk) begin
        // presync counts good headers, sync counts bad ones
        if ((state == atc_pkg::ST_PRES) == ok) cnt <= cnt + 4'h1;
        else cnt <= 4'h0; // [RULE_12]
      end
    end
  end

  // aligned octet position, restarted by a hunt match
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_pos <= 6'h00;
    end else if (state == atc_pkg::ST_HUNT) begin
      rx_pos <= hit_any ? atc_pkg::POS_PAY : 6'h00;
    end else begin
      rx_pos <= (rx_pos == atc_pkg::POS_LAST) ? 6'h00 : rx_pos + 6'h01;
    end
  end

  // loss of delineation status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lcd <= 1'b0;
    end else if (state == atc_pkg::ST_SYNC
                 && next_state == atc_pkg::ST_HUNT) begin
      lcd <= 1'b1; // [RULE_20]
    end else if (next_state == atc_pkg::ST_SYNC) begin
      lcd <= 1'b0; // [RULE_20]
    end
  end

  // correction or detection mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      corr_mode <= 1'b1;
    end else if (chk) begin
      corr_mode <= ok; // [RULE_19]
    end
  end

  // line shift register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_sr <= 48'h0;
    end else begin
      rx_sr <= {rx_sr[39:0], rx_line};
    end
  end

  // descrambler runs over the information field only
  assign dscr_en = (state != atc_pkg::ST_HUNT)
                   && (rx_pos >= atc_pkg::POS_PAY); // [RULE_17]
  assign rx_step = scr_step(rx_dsc, cand[7:0], 1'b1);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_dsc <= 43'h0;
    end else if (dscr_en) begin
      rx_dsc <= rx_step[50:8]; // [RULE_16]
    end
  end

  // payload delay so the header can go first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) pdly[i] <= 8'h00;
    end else begin
      pdly[0] <= dscr_en ? rx_step[7:0] : cand[7:0];
      for (int i = 1; i < 4; i++) pdly[i] <= pdly[i-1];
    end
  end

  // forwarding of good non idle cells in sync
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      emit_act <= 1'b0;
      ecnt <= 6'h00;
      rx_hdr <= 32'h0;
    end else if (fwd) begin
      emit_act <= 1'b1;
      ecnt <= 6'h00;
      rx_hdr <= hdr_fix; // [RULE_19]
    end else if (emit_act) begin
      emit_act <= (ecnt != atc_pkg::EMIT_LAST);
      ecnt <= ecnt + 6'h01;
    end
  end

  // upward cell octet register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cell <= '0;
    end else begin
      rx_cell.valid <= emit_act;
      rx_cell.sop <= emit_act && (ecnt == 6'h00);
      if (ecnt < atc_pkg::EMIT_HDR) begin
        rx_cell.data <= rx_hdr[8*(3-ecnt[1:0]) +: 8];
      end else begin
        rx_cell.data <= pdly[3];
      end
    end
  end

  // discarded errored headers while in sync
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drop_cnt <= 16'h0;
    end else if (chk && state == atc_pkg::ST_SYNC && !good) begin
      drop_cnt <= drop_cnt + 16'h1;
    end
  end

  // ---------------- axi4-lite slave
  logic aw_held, w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // write address and data taken in either order, then answered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= atc_pkg::RESP_OKAY;
      alpha <= atc_pkg::ALPHA_RST; // [RULE_14]
      delta <= atc_pkg::DELTA_RST; // [RULE_14]
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= atc_pkg::RESP_OKAY;
        if (aw_q == atc_pkg::ADDR_CTRL) begin
          if (ws_q[0]) alpha <= w_q[atc_pkg::CTRL_ALPHA_LSB +: 4];
          if (ws_q[1]) delta <= w_q[atc_pkg::CTRL_DELTA_LSB +: 4];
        end else if (aw_q != atc_pkg::ADDR_STAT
                     && aw_q != atc_pkg::ADDR_DROP) begin
          s_axi_bresp <= atc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= atc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= atc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        atc_pkg::ADDR_CTRL: begin
          s_axi_rdata[atc_pkg::CTRL_ALPHA_LSB +: 4] <= alpha;
          s_axi_rdata[atc_pkg::CTRL_DELTA_LSB +: 4] <= delta;
        end
        atc_pkg::ADDR_STAT: begin
          s_axi_rdata[atc_pkg::STAT_STATE_LSB +: 2] <= state;
          s_axi_rdata[atc_pkg::STAT_LCD_BIT] <= lcd;
          s_axi_rdata[atc_pkg::STAT_CORR_BIT] <= corr_mode;
        end
        atc_pkg::ADDR_DROP: s_axi_rdata <= {16'h0, drop_cnt};
        default: s_axi_rresp <= atc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- checks
  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_sync_lost;
    state == atc_pkg::ST_SYNC ##1 state == atc_pkg::ST_HUNT;
  endsequence
  sequence s_pres_bad;
    state == atc_pkg::ST_PRES && chk && !ok;
  endsequence

  hec_byte_a: assert property (tx_pos == atc_pkg::POS_HEC |=> // [RULE_04]
    tx_line.data == (crc_hdr($past(tx_hdr)) ^ atc_pkg::COSET))
    else $error("header check octet wrong");
  idle_hec_a: assert property (tx_pos == atc_pkg::POS_HEC // [RULE_07]
    && !tx_user |=> tx_line.data == atc_pkg::IDLE_HEC)
    else $error("idle check octet wrong");
  scr_hold_a: assert property (tx_pos < atc_pkg::POS_PAY // [RULE_16]
    |=> $stable(tx_scr)) else $error("scrambler moved in header");
  hunt_dscr_a: assert property (state == atc_pkg::ST_HUNT // [RULE_17]
    |=> $stable(rx_dsc)) else $error("descrambler moved in hunt");
  hunt_lock_a: assert property (state == atc_pkg::ST_HUNT // [RULE_10]
    && hit_any |=> state == atc_pkg::ST_PRES && rx_pos == atc_pkg::POS_PAY)
    else $error("hunt match not taken");
  pres_fail_a: assert property (s_pres_bad // [RULE_11]
    |=> state == atc_pkg::ST_HUNT) else $error("presync kept bad header");
  lcd_set_a: assert property (s_sync_lost |-> lcd // [RULE_20]
    ##1 (lcd throughout (state != atc_pkg::ST_SYNC)[*1]))
    else $error("loss status not raised");
  idle_drop_a: assert property (chk && idle |=> // [RULE_09]
    !emit_act ##1 !rx_cell.valid) else $error("idle cell forwarded");
  corr_mode_a: assert property (chk && !ok |=> !corr_mode) // [RULE_19]
    else $error("mode not left after error");
endmodule
`default_nettype wire

// ==== verif/atc_peer.sv ====
/*
  peer line model: the far end loops the block's transmit octets back,
  slipped by a fixed bit offset, and spoils check octets on command.
  assumes one line octet per clk, cell starts marked by sop.
*/
`timescale 1ns/1ps
`default_nettype none
module atc_peer #(
  parameter int SLIP = 3 // bit slip of the echoed stream
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire atc_pkg::atc_byte_t line_in,
  input wire logic spoil,
  output logic [7:0] line_out
);
  logic [5:0] pos; // next octet index within the cell
  logic [5:0] cur; // index of the octet now offered
  logic [7:0] din; // echoed octet, spoiled when asked
  logic [7:0] prev; // octet echoed one cycle before
  logic [15:0] pair; // older octet first, slipped below
  // cells are 53 octets counted from the start marker
  assign cur = line_in.sop ? 6'h00 : pos;
  // two bits flipped in the check octet cannot be corrected
  assign din = line_in.data ^ ((spoil && cur == 6'h04) ? 8'h03 : 8'h00);
  assign pair = {prev, din} >> SLIP;
  // position counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos <= 6'h00;
    end else begin
      pos <= cur + 6'h01;
    end
  end
  // echo with a bit slip so the receiver must hunt off octet edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= 8'h00;
      line_out <= 8'h00;
    end else begin
      prev <= din;
      line_out <= pair[7:0];
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
  self-checking bench: registers, transmit check octets and idle cells,
  delineation and forwarding over a looped, bit-slipped line.
  assumes the peer model echoes the transmit stream.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t %s", $time, m); end end
module tb_top;
  logic clk, sys_rst, tx_ready, lcd, spoil;
  atc_pkg::atc_byte_t tx_cell, tx_line, rx_cell;
  logic [7:0] rx_line, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, hdr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int n_fail, num_checks, n, tpos, rpos, rcells, idles;
  logic [15:0] rnd; // bench random state
  logic [7:0] exp_q[$]; // octets expected upward
  logic [31:0] thdr; // transmit header seen so far
  logic [42:0] thist; // bench descrambler history
  logic [7:0] plain; // descrambled transmit octet
  atc_tc atc_tc_inst (.clk, .sys_rst, .tx_cell, .tx_ready, .tx_line,
    .rx_line, .rx_cell, .lcd, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  atc_peer atc_peer_inst (.clk(clk), .sys_rst(sys_rst), .line_in(tx_line),
    .spoil(spoil), .line_out(rx_line));
  // bench random source
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // expected check octet, first header bit as top coefficient
  function automatic logic [7:0] hec_of(input logic [31:0] h);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ h[i]) ? 8'h07 : 8'h00);
    end
    return r ^ 8'h55;
  endfunction
  // print the counts and the verdict, then stop
  task automatic give_verdict(input bit hung);
    if (hung) n_fail++;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one register write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    rs = s_axi_bresp;
    if (n >= 50) give_verdict(1);
  endtask
  // one register read
  task automatic axi_rd(input logic [7:0] a);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    if (n >= 50) give_verdict(1);
  endtask
  // one user cell of 52 octets, payload random
  task automatic send_cell(input logic [31:0] h);
    logic [7:0] o;
    for (int i = 0; i < 52; i++) begin
      rnd = lfsr(rnd);
      o = (i < 4) ? h[31 - 8 * i -: 8] : rnd[7:0];
      exp_q.push_back(o);
      tx_cell <= '{1'b1, i == 0, o};
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!tx_ready && n < 200);
      if (n >= 200) give_verdict(1);
    end
  endtask
  // spoil the check octet of k whole cells
  task automatic spoil_cells(input int k);
    for (int c = 0; c <= k; c++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!tx_line.sop && n < 100);
      spoil <= (c < k);
    end
  endtask
  // transmit monitor: check octets and descrambled idle payload
  always @(negedge clk) begin
    if (!sys_rst && tx_line.valid) begin
      tpos = tx_line.sop ? 0 : tpos + 1;
      if (tpos < 4) thdr = {thdr[23:0], tx_line.data};
      if (tpos == 4) `CHK(tx_line.data, hec_of(thdr), "check octet")
      if (tpos == 4 && thdr == 32'h1) idles++;
      if (tpos > 4) begin
        for (int b = 7; b >= 0; b--) begin
          plain[b] = tx_line.data[b] ^ thist[42];
          thist = {thist[41:0], tx_line.data[b]};
        end
        if (thdr == 32'h1 && idles > 1) `CHK(plain, 8'h6A, "idle payload")
      end
    end
  end
  // receive monitor: forwarded octets against what was sent
  always @(negedge clk) begin
    if (!sys_rst && rx_cell.valid) begin
      `CHK(rx_cell.sop, rpos == 0, "cell start")
      rpos = (rpos + 1) % 52;
      if (rx_cell.sop) rcells++;
      `CHK(exp_q.size() > 0, 1'b1, "unexpected cell")
      if (exp_q.size() > 0) `CHK(rx_cell.data, exp_q.pop_front(), "rx octet")
    end
  end
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // main sequence
  initial begin
    {sys_rst, spoil, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, tx_cell} = {32'h0, 4'hF, 10'h000};
    {n_fail, num_checks, tpos, rpos, rcells, idles} = '0;
    {rnd, thdr, thist} = {16'h0025, 75'h0};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    axi_rd(atc_pkg::ADDR_CTRL);
    `CHK(rd[11:0], 12'h607, "threshold defaults")
    axi_rd(8'h0C);
    `CHK({rs, rd}, {2'h2, 32'h0}, "unmapped read")
    axi_wr(8'h10, 32'h0);
    `CHK(rs, 2'h2, "unmapped write")
    // only the alpha byte is enabled, so delta must keep its default
    s_axi_wstrb <= 4'h1;
    axi_wr(atc_pkg::ADDR_CTRL, 32'h0000_0E03);
    `CHK(rs, 2'h0, "threshold write response")
    axi_rd(atc_pkg::ADDR_CTRL);
    `CHK(rd[11:0], 12'h603, "threshold write")
    for (int w = 0; w < 200 && rd[1:0] !== 2'h2; w++) begin
      repeat (20) @(posedge clk);
      axi_rd(atc_pkg::ADDR_STAT);
    end
    `CHK({lcd, rd[2:0]}, 4'h2, "sync reached")
    for (int c = 0; c < 6; c++) begin
      rnd = lfsr(rnd);
      hdr = {rnd, lfsr(rnd)} | 32'h0000_0100;
      send_cell(hdr);
    end
    @(posedge clk);
    tx_cell <= '0;
    repeat (200) @(posedge clk);
    `CHK(exp_q.size(), 0, "cells forwarded")
    `CHK(rcells, 6, "forwarded cell count")
    spoil_cells(2);
    repeat (100) @(posedge clk);
    axi_rd(atc_pkg::ADDR_STAT);
    `CHK({lcd, rd[1:0]}, 3'h2, "two bad headers kept")
    `CHK(rd[3], 1'b1, "correction mode back")
    axi_rd(atc_pkg::ADDR_DROP);
    `CHK(rd, 32'h2, "errored headers dropped")
    spoil_cells(3);
    repeat (100) @(posedge clk);
    axi_rd(atc_pkg::ADDR_STAT);
    `CHK({lcd, rd[2]}, 2'h3, "delineation lost")
    for (int w = 0; w < 3000 && lcd !== 1'b0; w++) @(posedge clk);
    axi_rd(atc_pkg::ADDR_STAT);
    `CHK({lcd, rd[2:0]}, 4'h2, "sync regained")
    `CHK(idles > 2, 1'b1, "idle cells sent")
    give_verdict(0);
  end
endmodule
`default_nettype wire
